// ==== hw/hsp_top.sv ====
// host serial port: SPI slave or UART picked by the select pin, tx byte fifo
// assumes the five pad pins asynchronous to I_CLK_SYS, host-side pins synchronous to it; SCLK at most a twelfth of it
`timescale 1ns/1ps

module hsp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign o_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign o_valid = wr_q != rd_q;
  assign o_data = mem[rd_q[AW-1:0]];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule // hsp_fifo

module hsp_top
  import hsp_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic I_RESET_N,
  input wire logic I_SSEL,
  input wire logic I_CS_N,
  input wire logic I_SCLK,
  input wire logic I_SDI_RX,
  output logic O_SDO_TX,
  output logic O_SDO_TX_OE,
  input wire logic I_BAUD_WE,
  input wire logic [15:0] I_BAUD_DATA,
  input wire logic I_TX_VALID,
  input wire logic [7:0] I_TX_DATA,
  output logic O_TX_READY,
  output logic O_RX_VALID,
  output hsp_rx_t O_RX,
  output logic O_READY
);
  localparam int INIT_MAX = 8;

  logic [4:0] pins;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic rstn_s, ssel_s, cs_n_s, sclk_s, sdi_s;
  logic sclk_d_q;
  logic sclk_rise, sclk_fall;
  logic [11:0] rstn_low_cnt_q;
  logic chip_rst_q;
  hsp_init_t init_st_q;
  logic [2:0] init_cnt_q;
  logic core_rst;
  logic uart_mode, spi_on, uart_on;
  logic [15:0] serial_control_reg_q;
  logic [15:0] baud_divisor_field;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W+1:0] acc_sum;
  logic tick;
  logic f_valid, f_pop;
  logic [7:0] f_data;
  logic spi_started_q, spi_need_q;
  logic [2:0] spi_bit_q;
  logic [7:0] spi_rx_sh_q, spi_tx_sh_q;
  logic spi_load, spi_push, spi_pop;
  hsp_rxst_t rx_st_q;
  logic [3:0] rx_ovs_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic uart_push, uart_err, rx_line_q;
  hsp_txst_t tx_st_q;
  logic [3:0] tx_ovs_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;
  logic uart_pop, uart_line;

  // pin synchronisers reset to idle pin levels, so no false sclk edge after reset
  assign pins = {I_RESET_N, I_SSEL, I_CS_N, I_SCLK, I_SDI_RX};
  generate
    for (genvar g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
          sync1_q[g] <= SYNC_RESET[g];
          sync2_q[g] <= SYNC_RESET[g];
        end else begin
          sync1_q[g] <= pins[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate
  assign {rstn_s, ssel_s, cs_n_s, sclk_s, sdi_s} = sync2_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      sclk_d_q <= 1'b0;
      rx_line_q <= 1'b1;
    end else begin
      sclk_d_q <= sclk_s;
      rx_line_q <= sdi_s;
    end
  end
  assign sclk_rise = sclk_s && !sclk_d_q;
  assign sclk_fall = !sclk_s && sclk_d_q;

  // short glitches on the reset pin are ignored by the low-time filter
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || rstn_s) begin
      rstn_low_cnt_q <= '0;
      chip_rst_q <= 1'b0;
    end else if (rstn_low_cnt_q == RST_CNT_LAST) begin
      chip_rst_q <= 1'b1;
    end else begin
      rstn_low_cnt_q <= rstn_low_cnt_q + 12'h001;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || chip_rst_q) begin
      init_st_q <= ST_RST;
      init_cnt_q <= '0;
    end else begin
      case (init_st_q)
        ST_RST: begin
          init_st_q <= ST_INIT;
          init_cnt_q <= '0;
        end
        ST_INIT: begin
          init_cnt_q <= init_cnt_q + 3'h1;
          if (init_cnt_q == INIT_LAST) begin
            init_st_q <= ST_RUN;
          end
        end
        ST_RUN: init_st_q <= ST_RUN;
        default: init_st_q <= ST_RST;
      endcase
    end
  end
  assign core_rst = init_st_q != ST_RUN;
  assign O_READY = !core_rst;

  assign uart_mode = ssel_s;
  assign spi_on = !uart_mode && !cs_n_s && !core_rst;
  assign uart_on = uart_mode && !cs_n_s && !core_rst;

  always_ff @(posedge I_CLK_SYS) begin
    if (init_st_q != ST_RUN) begin
      serial_control_reg_q <= {16'h0000 | BAUD_RESET};
    end else if (I_BAUD_WE) begin
      serial_control_reg_q <= I_BAUD_DATA;
    end
  end
  assign baud_divisor_field = serial_control_reg_q;

  // 16x tick at field * f_clk / 2^19 * 16; remainder kept, so no rate drift
  assign acc_sum = (ACC_W+2)'(acc_q) + (ACC_W+2)'(baud_divisor_field);
  assign tick = |acc_sum[ACC_W+1:ACC_W];
  always_ff @(posedge I_CLK_SYS) begin
    if (core_rst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_sum[ACC_W-1:0];
    end
  end

  hsp_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .i_clk(I_CLK_SYS),
    .i_srst(core_rst),
    .i_valid(I_TX_VALID),
    .i_data(I_TX_DATA),
    .o_ready(O_TX_READY),
    .o_valid(f_valid),
    .o_data(f_data),
    .i_ready(f_pop)
  );
  assign f_pop = spi_pop || uart_pop;

  // spi: first byte loaded at select, next one on the fall after the 8th rise
  assign spi_load = spi_on && (!spi_started_q || (sclk_fall && spi_need_q));
  assign spi_pop = spi_load && f_valid;
  assign spi_push = spi_on && sclk_rise && spi_bit_q == BYTE_LAST_BIT;
  always_ff @(posedge I_CLK_SYS) begin
    if (!spi_on) begin
      spi_started_q <= 1'b0;
      spi_need_q <= 1'b0;
      spi_bit_q <= '0;
      spi_rx_sh_q <= '0;
      spi_tx_sh_q <= '0;
    end else begin
      if (spi_load) begin
        spi_started_q <= 1'b1;
        spi_need_q <= 1'b0;
        spi_tx_sh_q <= f_valid ? f_data : SPI_IDLE_BYTE;
      end else if (sclk_fall) begin
        spi_tx_sh_q <= {spi_tx_sh_q[6:0], 1'b0};
      end
      if (sclk_rise) begin
        spi_rx_sh_q <= {spi_rx_sh_q[6:0], sdi_s};
        spi_bit_q <= spi_bit_q + 3'h1;
        if (spi_bit_q == BYTE_LAST_BIT) begin
          spi_need_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!uart_on) begin
      rx_st_q <= RX_IDLE;
      rx_ovs_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
    end else begin
      if (tick) begin
        rx_ovs_q <= rx_ovs_q + 4'h1;
      end
      case (rx_st_q)
        RX_IDLE: begin
          rx_ovs_q <= '0;
          // falling edge only: a low stop bit must not restart a frame
          if (!sdi_s && rx_line_q) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: if (tick && rx_ovs_q == OVS_MID) begin
          rx_ovs_q <= '0;
          rx_bit_q <= '0;
          rx_st_q <= sdi_s ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (tick && rx_ovs_q == OVS_LAST) begin
          rx_sh_q <= {sdi_s, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == BYTE_LAST_BIT) begin
            rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: if (tick && rx_ovs_q == OVS_LAST) begin
          rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end
  assign uart_push = uart_on && rx_st_q == RX_STOP && tick && rx_ovs_q == OVS_LAST;
  assign uart_err = !sdi_s;

  always_ff @(posedge I_CLK_SYS) begin
    if (core_rst) begin
      O_RX_VALID <= 1'b0;
      O_RX <= '0;
    end else begin
      O_RX_VALID <= spi_push || uart_push;
      if (spi_push) begin
        O_RX <= '{frame_err: 1'b0, data: {spi_rx_sh_q[6:0], sdi_s}};
      end else if (uart_push) begin
        O_RX <= '{frame_err: uart_err, data: rx_sh_q};
      end
    end
  end

  // deselect mid-character drops the rest of it rather than stall the fifo
  // frame starts on a tick, so the start bit lasts the full 16 ticks
  assign uart_pop = uart_on && tx_st_q == TX_IDLE && f_valid && tick;
  always_ff @(posedge I_CLK_SYS) begin
    if (!uart_on) begin
      tx_st_q <= TX_IDLE;
      tx_ovs_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '1;
    end else begin
      case (tx_st_q)
        TX_IDLE: if (f_valid && tick) begin
          tx_sh_q <= {1'b1, f_data, 1'b0};
          tx_ovs_q <= '0;
          tx_bit_q <= '0;
          tx_st_q <= TX_SEND;
        end
        TX_SEND: if (tick) begin
          tx_ovs_q <= tx_ovs_q + 4'h1;
          if (tx_ovs_q == OVS_LAST) begin
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == UART_LAST_BIT) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
  assign uart_line = tx_st_q == TX_SEND ? tx_sh_q[0] : 1'b1;

  always_ff @(posedge I_CLK_SYS) begin
    if (core_rst) begin
      O_SDO_TX <= 1'b1;
      O_SDO_TX_OE <= 1'b0;
    end else begin
      O_SDO_TX <= uart_mode ? uart_line : spi_tx_sh_q[7];
      O_SDO_TX_OE <= spi_on || uart_on;
    end
  end

  property p_mode_line;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (uart_on && !$past(core_rst)) |=> O_SDO_TX == $past(uart_line) && O_SDO_TX_OE;
  endproperty
  a_mode_line: assert property (p_mode_line) else $error("uart line not on pin");

  property p_cs_release;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (!uart_mode && cs_n_s) |=> !O_SDO_TX_OE && spi_bit_q == 3'h0 && !spi_started_q;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("spi active while deselected");

  property p_push_cs;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    spi_push |-> !cs_n_s && !uart_mode ##1 O_RX_VALID && !O_RX.frame_err;
  endproperty
  a_push_cs: assert property (p_push_cs) else $error("spi byte outside select");

  property p_msb_in;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (spi_on && sclk_rise) |=> spi_rx_sh_q == {$past(spi_rx_sh_q[6:0]), $past(sdi_s)};
  endproperty
  a_msb_in: assert property (p_msb_in) else $error("spi input not msb first");

  property p_change_on_fall;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (spi_on && spi_started_q && !sclk_fall) ##1 spi_on |-> $stable(spi_tx_sh_q);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall) else $error("sdo moved off a fall");

  property p_tx_frame;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    uart_pop |=> tx_sh_q == {1'b1, $past(f_data), 1'b0} && tx_st_q == TX_SEND;
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("bad uart frame load");

  property p_tx_lsb;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (tx_st_q == TX_SEND && tick && tx_ovs_q == OVS_LAST) ##1 uart_on
      |-> tx_sh_q == {1'b1, $past(tx_sh_q[9:1])};
  endproperty
  a_tx_lsb: assert property (p_tx_lsb) else $error("uart not lsb first");

  property p_baud_default;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (init_st_q == ST_INIT) |=> baud_divisor_field == BAUD_RESET;
  endproperty
  a_baud_default: assert property (p_baud_default) else $error("baud default wrong");

  property p_rst_filter;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    $rose(chip_rst_q) |-> $past(rstn_low_cnt_q) == RST_CNT_LAST && !$past(rstn_s);
  endproperty
  a_rst_filter: assert property (p_rst_filter) else $error("chip reset too early");

  property p_init_seq;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    $fell(chip_rst_q) |-> ##[1:INIT_MAX] init_st_q == ST_RUN;
  endproperty
  a_init_seq: assert property (p_init_seq) else $error("init did not finish");

  property p_uart_desel;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    (uart_mode && cs_n_s) |=> !O_SDO_TX_OE ##1 !O_RX_VALID;
  endproperty
  a_uart_desel: assert property (p_uart_desel) else $error("uart active deselected");
endmodule // hsp_top

// ==== include/hsp_pkg.sv ====
// constants, carriers and state codes of the host serial port
// assumes one 20 MHz system clock that also serves as the master clock
// Contract
// - select low uses SPI, high uses UART
// - select pin pulled up, open means UART
// - slave-only four-wire SPI, shared bus allowed
// - chip select high: output off, SPI cleared
// - SPI answers only while chip select low
// - change after SCLK fall, sample on rise
// - SPI bytes shifted MSB first
// - full-duplex UART, two-wire or three-wire mode
// - UART character: start, eight data, stop
// - UART data bits LSB first
// - baud divisor field sets UART bit rate
// - divisor resets to 600 baud at 4.096 MHz
// - UART reaches 512K baud at nominal clock
// - reset pin low over 120 us resets all
// - reset release runs default-loading init
package hsp_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RESET_LOW_NS = 120_000;
  // least time, so round up
  localparam int unsigned RESET_LOW_CYC = (RESET_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [11:0] RST_CNT_LAST = 12'(RESET_LOW_CYC - 1);
  localparam logic [2:0] INIT_LAST = 3'h3;
  localparam logic [15:0] BAUD_RESET = 16'h004D;
  localparam int unsigned BAUD_LOG2 = 19;
  localparam int unsigned OVS_LOG2 = 4;
  localparam int unsigned ACC_W = BAUD_LOG2 - OVS_LOG2;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] UART_LAST_BIT = 4'h9;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [7:0] SPI_IDLE_BYTE = 8'h00;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [4:0] SYNC_RESET = 5'h1D;

  typedef struct packed {
    logic frame_err;
    logic [7:0] data;
  } hsp_rx_t;

  typedef enum logic [2:0] {
    ST_RST = 3'h1,
    ST_INIT = 3'h2,
    ST_RUN = 3'h4
  } hsp_init_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } hsp_rxst_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_SEND = 2'h2
  } hsp_txst_t;
endpackage

// ==== test/hsp_host.sv ====
// host model: SPI master in mode 0 and UART peer on the pads
// assumes i_line is the resolved TX/SDO pad and i_clk the device clock
`timescale 1ns/1ps

module hsp_host (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi
);
  int bclk = 128;

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b1;
  end

  task automatic cs(input logic v);
    @(posedge i_clk);
    o_cs_n <= v;
    repeat (8) @(posedge i_clk);
  endtask

  // six clocks a phase: the device sees the pads through synchronisers
  task automatic spi(input logic [7:0] t, input int n, output logic [7:0] r);
    r = 8'h00;
    @(posedge i_clk);
    for (int i = 7; i > 7 - n; i--) begin
      o_sdi <= t[i];
      repeat (6) @(posedge i_clk);
      o_sclk <= 1'b1;
      r[i] = i_line;
      repeat (6) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
  endtask

  task automatic tx(input logic [7:0] d, input logic s);
    logic [9:0] f;
    f = {s, d, 1'b0};
    @(posedge i_clk);
    for (int i = 0; i < 10; i++) begin
      o_sdi <= f[i];
      repeat (bclk) @(posedge i_clk);
    end
    o_sdi <= 1'b1;
  endtask

  // samples mid-bit on the falling clock, away from the pad's updates
  task automatic rx(output logic [7:0] d, output logic ok);
    logic [9:0] f;
    int n;
    n = 0;
    while (i_line !== 1'b0 && n < 20000) begin
      @(negedge i_clk);
      n++;
    end
    repeat (bclk / 2) @(negedge i_clk);
    for (int i = 0; i < 10; i++) begin
      f[i] = i_line;
      if (i < 9) repeat (bclk) @(negedge i_clk);
    end
    d = f[8:1];
    ok = (n < 20000) && f[0] === 1'b0 && f[9] === 1'b1;
  endtask
endmodule // hsp_host

// ==== test/hsp_top_tb.sv ====
// bench of the host serial port: UART both ways, SPI, tx fifo, chip reset
// assumes hsp_host on the pads; TX/SDO pad resolved here from its enable
`timescale 1ns/1ps
`define CK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module hsp_top_tb
  import hsp_pkg::*;
;
  logic clk = 1'b0;
  logic srst, rst_n, ssel, we, tv;
  logic [15:0] bd;
  logic [7:0] td;
  logic last_q = 1'b1;
  logic sdo, oe, trdy, rv, rdy;
  hsp_rx_t rxo;
  wire cs_n, sclk, sdi, line;
  int miscompares = 0;
  int tests_run = 0;
  hsp_rx_t rxq[$];
  logic [7:0] txq[$];

  always #25 clk = ~clk;
  // released pad shows the inverse of its last value
  assign line = oe ? sdo : ~last_q;
  always @(posedge clk) begin
    if (rv === 1'b1) rxq.push_back(rxo);
    if (oe === 1'b1) last_q <= sdo;
  end

  hsp_top i_hsp_top (.I_CLK_SYS(clk), .I_SRST(srst), .I_RESET_N(rst_n), .I_SSEL(ssel),
    .I_CS_N(cs_n), .I_SCLK(sclk), .I_SDI_RX(sdi), .O_SDO_TX(sdo), .O_SDO_TX_OE(oe),
    .I_BAUD_WE(we), .I_BAUD_DATA(bd), .I_TX_VALID(tv), .I_TX_DATA(td),
    .O_TX_READY(trdy), .O_RX_VALID(rv), .O_RX(rxo), .O_READY(rdy));
  hsp_host i_hsp_host (.i_clk(clk), .i_line(line), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_sdi(sdi));

  function automatic int bits(input logic [15:0] br);
    return 32'h0008_0000 / br;
  endfunction

  function automatic hsp_rx_t ex(input logic [7:0] d, input logic s);
    return '{frame_err: ~s, data: d};
  endfunction

  task automatic results();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // valid stays up so bursts go back to back; caller drops it
  task automatic push(input logic [7:0] d);
    int n;
    n = 0;
    tv <= 1'b1;
    td <= d;
    @(negedge clk);
    while (trdy !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    `CK("tx_take", 1'b1, trdy)
    @(posedge clk);
  endtask

  task automatic baud(input logic [15:0] v);
    @(posedge clk);
    we <= 1'b1;
    bd <= v;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic waitr(input int lim);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    `CK("ready", 1'b1, rdy)
  endtask

  task automatic rxc(input hsp_rx_t e);
    hsp_rx_t w;
    w = '0;
    `CK("rx_count", 1, rxq.size())
    if (rxq.size() > 0) begin
      w = rxq.pop_front();
      `CK("rx_word", e, w)
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    results();
  end

  initial begin
    logic [7:0] a, b, g;
    logic [15:0] br;
    logic ok;
    int n;
    srst = 1'b1;
    rst_n = 1'b1;
    // open pin reads high through its pull-up
    ssel = 1'b1;
    we = 1'b0;
    tv = 1'b0;
    bd = 16'h0000;
    td = 8'h00;
    void'($urandom(76201));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    `CK("oe_rst", 1'b0, oe)
    waitr(10);
    i_hsp_host.cs(1'b0);
    @(negedge clk);
    `CK("uart_oe", 1'b1, oe)
    `CK("uart_idle", 1'b1, sdo)
    for (int k = 0; k < 2; k++) begin
      br = k ? 16'h346E : 16'h1000;
      baud(br);
      i_hsp_host.bclk = bits(br);
      for (int i = 0; i < 5; i++) begin
        a = (i == 0) ? 8'h01 : 8'($urandom);
        b = (i == 0) ? 8'h80 : 8'($urandom);
        @(posedge clk);
        push(b);
        tv <= 1'b0;
        fork
          i_hsp_host.tx(a, i != 4);
          i_hsp_host.rx(g, ok);
        join
        `CK("uart_frame", 1'b1, ok)
        `CK("uart_tx", b, g)
        rxc(ex(a, i != 4));
      end
    end
    i_hsp_host.cs(1'b1);
    `CK("uart_cs_oe", 1'b0, oe)
    i_hsp_host.tx(8'h5A, 1'b1);
    `CK("uart_cs_rx", 0, rxq.size())
    @(posedge clk);
    ssel <= 1'b0;
    repeat (8) @(negedge clk);
    `CK("spi_cs_oe", 1'b0, oe)
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      b = 8'($urandom);
      txq.push_back(b);
      push(b);
    end
    tv <= 1'b0;
    @(negedge clk);
    `CK("fifo_full", 1'b0, trdy)
    i_hsp_host.cs(1'b0);
    for (int i = 0; i < 17; i++) begin
      a = 8'($urandom);
      i_hsp_host.spi(a, 8, g);
      `CK("spi_sdo", (i < 16) ? txq[i] : SPI_IDLE_BYTE, g)
      rxc(ex(a, 1'b1));
    end
    `CK("fifo_empty", 1'b1, trdy)
    i_hsp_host.spi(8'hFF, 3, g);
    i_hsp_host.cs(1'b1);
    `CK("spi_off", 1'b0, oe)
    i_hsp_host.spi(8'hA5, 8, g);
    `CK("spi_ignored", 0, rxq.size())
    i_hsp_host.cs(1'b0);
    a = 8'($urandom);
    i_hsp_host.spi(a, 8, g);
    rxc(ex(a, 1'b1));
    i_hsp_host.cs(1'b1);
    ssel <= 1'b1;
    rst_n <= 1'b0;
    repeat (100) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    `CK("short_low", 1'b1, rdy)
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2390) @(negedge clk);
    `CK("low_early", 1'b1, rdy)
    repeat (20) @(negedge clk);
    `CK("long_low", 1'b0, rdy)
    @(posedge clk);
    rst_n <= 1'b1;
    waitr(12);
    i_hsp_host.cs(1'b0);
    push(8'h01);
    tv <= 1'b0;
    n = 0;
    while (line !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (line === 1'b0 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    `CK("default_bit", 1'b1, n > bits(BAUD_RESET) - 68 && n < bits(BAUD_RESET) + 68)
    results();
  end
endmodule // hsp_top_tb
